// File: hbl_defines.vh
// Constants for the host boot image loader: register map, fields, timing
`ifndef HBL_DEFINES_VH
`define HBL_DEFINES_VH

// ****************************************************************
// Register byte offsets on the Wishbone slave
// ****************************************************************
`define HBL_REG_CTRL 4'h0
`define HBL_REG_STATUS 4'h4
`define HBL_REG_IMAGE 4'h8
`define HBL_REG_ADDR 4'hC

// ****************************************************************
// Control register fields
// ****************************************************************
`define HBL_CTRL_START 0

// ****************************************************************
// Image header fields
// ****************************************************************
`define HBL_C1_WAIT_LSB 0
`define HBL_C1_WAIT_MSB 2
`define HBL_C1_DIV_LSB 3
`define HBL_C1_DIV_MSB 5
`define HBL_C1_SPI_SEL 6
`define HBL_C2_WIDE_IMG 0
`define HBL_C2_CRC 1
`define HBL_FLAG_MEM16 0
`define HBL_FLAG_FINAL 1
`define HBL_FLAG_ZERO 2
`define HBL_FLAG_EXT16 4

// ****************************************************************
// Target locations and values
// ****************************************************************
`define HBL_SYSCFG_ADDR 24'h000204
`define HBL_SEMA_ADDR 24'h0039F8
`define HBL_SEMA_GO 24'h000001
`define HBL_RSV_WORDS 16'h0110
`define HBL_RESET_VALUE_STATUS 32'h0000_0000

// ****************************************************************
// Timing
// ****************************************************************
`define HBL_CLK_NS 8
`define HBL_TGT_RST_NS 1000

`endif

// File: hbl_tgt_port.v
// Four-phase write engine towards the target host port
`timescale 1ns/1ps
`default_nettype none

module hbl_tgt_port (
    // Clock and reset
    input wire clk_sys_i,
    input wire arst_n_i,
    // Command from the loader
    input wire cmd_i,
    input wire cmd_io_i,
    input wire cmd_mem16_i,
    input wire [23:0] cmd_addr_i,
    input wire [23:0] cmd_data_i,
    output wire busy_o,
    output reg done_o,
    // Target side
    output reg tgt_req_o,
    output reg tgt_io_o,
    output reg tgt_mem16_o,
    output reg [23:0] tgt_addr_o,
    output reg [23:0] tgt_data_o,
    input wire tgt_ack_i
);

    reg ack_meta_ff;
    reg ack_sync_ff;
    reg active_ff;

    assign busy_o = active_ff;

    // ****************************************************************
    // Ack synchroniser
    // ****************************************************************
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_meta_ff <= 1'b0;
            ack_sync_ff <= 1'b0;
        end else begin
            ack_meta_ff <= tgt_ack_i;
            ack_sync_ff <= ack_meta_ff;
        end
    end

    // ****************************************************************
    // Handshake
    // ****************************************************************
    // Full four-phase so a slow target can never see a merged request
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            active_ff <= 1'b0;
            done_o <= 1'b0;
            tgt_req_o <= 1'b0;
            tgt_io_o <= 1'b0;
            tgt_mem16_o <= 1'b0;
            tgt_addr_o <= 24'h000000;
            tgt_data_o <= 24'h000000;
        end else begin
            done_o <= 1'b0;
            if (!active_ff) begin
                if (cmd_i) begin
                    active_ff <= 1'b1;
                    tgt_req_o <= 1'b1;
                    tgt_io_o <= cmd_io_i;
                    tgt_mem16_o <= cmd_mem16_i;
                    tgt_addr_o <= cmd_addr_i;
                    tgt_data_o <= cmd_data_i;
                end
            end else if (tgt_req_o) begin
                if (ack_sync_ff) begin
                    tgt_req_o <= 1'b0;
                end
            end else if (!ack_sync_ff) begin
                active_ff <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// File: hbl_loader.v
// Host boot loader: parses a 16-bit boot image and writes it into the target
// Functional notes
// - Host loads every block before writing the release semaphore.
// - Avoid static placement in last 272 page-zero data words during boot.
// - Image opens with two control words, eight useful bits each.
// - External wait states and clock divider apply only to external blocks.
// - Control one bit 6 is copied into system config bit 0.
// - Control two bit 0 gives image width, bit 1 checksum presence; the loader only shows both in status.
// - Block headers follow, each starting with a 16-bit flag word.
// - Flag bit 0 zero means 24-bit memory, one means 16-bit.
// - Flag bit 1 marks the final block; parsing stops after it.
// - Flag bit 2 clear copies payload, set writes zeros instead.
// - Flag bit 4 selects 16-bit or 8-bit external bus width.
// - Non-zero high address word means the block is external.
// - Address is low word plus low byte of high word; top byte zero.
// - Count gives target words; 24-bit memory needs two image words each.
// - Zero-fill count gives target words to clear.
// - 24-bit value: even word upper sixteen, odd word high byte lower eight.
`include "hbl_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module hbl_loader #(
    parameter TGT_RST_CYC = (`HBL_TGT_RST_NS + `HBL_CLK_NS - 1) / `HBL_CLK_NS
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire arst_n_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Target reset and boot straps
    output reg tgt_rst_n_o,
    output reg op_select_strap_o,
    output reg boot_strap_lo_o,
    output reg boot_strap_hi_o,
    // Target write port
    output wire tgt_req_o,
    output wire tgt_io_o,
    output wire tgt_mem16_o,
    output wire [23:0] tgt_addr_o,
    output wire [23:0] tgt_data_o,
    input wire tgt_ack_i,
    // External port settings for external blocks
    output reg ext_cfg_valid_o,
    output reg [2:0] ext_wait_o,
    output reg [2:0] ext_clk_div_o,
    output reg ext_bus16_o
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_RESET = 4'h1;
    localparam [3:0] S_CTRL1 = 4'h2;
    localparam [3:0] S_CTRL2 = 4'h3;
    localparam [3:0] S_FLAG = 4'h4;
    localparam [3:0] S_AHI = 4'h5;
    localparam [3:0] S_ALO = 4'h6;
    localparam [3:0] S_COUNT = 4'h7;
    localparam [3:0] S_DHI = 4'h8;
    localparam [3:0] S_DLO = 4'h9;
    localparam [3:0] S_ZERO = 4'hA;
    localparam [3:0] S_WAIT = 4'hB;
    localparam [3:0] S_SYSCFG = 4'hC;
    localparam [3:0] S_SEMA = 4'hD;
    localparam [3:0] S_DONE = 4'hE;
    localparam [3:0] S_ERROR = 4'hF;

    localparam [15:0] RSV_LO = 16'hFFFF - `HBL_RSV_WORDS + 16'h0001;
    localparam [15:0] RST_CYC = TGT_RST_CYC[15:0];

    reg [3:0] state_ff;
    reg [3:0] ret_ff;
    reg [15:0] rst_cnt_ff;
    reg [7:0] ctrl1_ff;
    reg [7:0] ctrl2_ff;
    reg [15:0] flag_ff;
    reg [7:0] addr_hi_ff;
    reg [23:0] addr_ff;
    reg [15:0] cnt_ff;
    reg [15:0] upper_ff;
    reg done_ff;
    reg err_ff;
    reg rsv_warn_ff;

    reg cmd_ff;
    reg cmd_io_ff;
    reg cmd_mem16_ff;
    reg [23:0] cmd_addr_ff;
    reg [23:0] cmd_data_ff;
    wire eng_done;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire img_sel = (wb_adr_i == `HBL_REG_IMAGE);
    wire need_word = (state_ff == S_CTRL1) | (state_ff == S_CTRL2) | (state_ff == S_FLAG) |
                     (state_ff == S_AHI) | (state_ff == S_ALO) | (state_ff == S_COUNT) |
                     (state_ff == S_DHI) | (state_ff == S_DLO);
    // Image writes stall on ack until the parser wants a word
    wire img_take = bus_req & wb_we_i & img_sel & need_word & (&wb_sel_i[1:0]);
    wire bus_done = bus_req & (~(wb_we_i & img_sel) | img_take);
    wire [15:0] word = wb_dat_i[15:0];
    wire start = bus_req & wb_we_i & (wb_adr_i == `HBL_REG_CTRL) & wb_sel_i[0] &
                 wb_dat_i[`HBL_CTRL_START];

    wire is_mem16 = flag_ff[`HBL_FLAG_MEM16];
    wire is_final = flag_ff[`HBL_FLAG_FINAL];
    wire is_zero = flag_ff[`HBL_FLAG_ZERO];
    wire is_ext = (addr_hi_ff != 8'h00);
    wire [15:0] cnt_dec = cnt_ff - 16'h0001;
    wire [3:0] after_block = is_final ? S_SYSCFG : S_FLAG;
    wire [3:0] after_write = (cnt_dec == 16'h0000) ? after_block : (is_zero ? S_ZERO : S_DHI);
    wire in_rsv = is_mem16 & ~is_ext & (addr_ff[23:16] == 8'h00) & (addr_ff[15:0] >= RSV_LO);

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `HBL_RESET_VALUE_STATUS;
        end else begin
            wb_ack_o <= bus_done;
            wb_dat_o <= 32'h0000_0000;
            if (bus_done & ~wb_we_i) begin
                case (wb_adr_i)
                    `HBL_REG_STATUS: begin
                        wb_dat_o <= {8'h00, ctrl1_ff, 4'h0, state_ff,
                                     ctrl1_ff[`HBL_C1_SPI_SEL], ctrl2_ff[`HBL_C2_CRC],
                                     ctrl2_ff[`HBL_C2_WIDE_IMG], need_word, rsv_warn_ff,
                                     err_ff, done_ff, (state_ff != S_IDLE) & ~done_ff & ~err_ff};
                    end
                    `HBL_REG_ADDR: begin
                        wb_dat_o <= {8'h00, addr_ff};
                    end
                    default: begin
                        wb_dat_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Target reset and straps
    // ****************************************************************
    // Straps stay at host-boot levels; only reset release latches them
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tgt_rst_n_o <= 1'b0;
            op_select_strap_o <= 1'b0;
            boot_strap_lo_o <= 1'b0;
            boot_strap_hi_o <= 1'b1;
        end else begin
            op_select_strap_o <= 1'b0;
            boot_strap_lo_o <= 1'b0;
            boot_strap_hi_o <= 1'b1;
            tgt_rst_n_o <= (state_ff != S_RESET);
        end
    end

    // ****************************************************************
    // Parser
    // ****************************************************************
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= S_IDLE;
            ret_ff <= S_IDLE;
            rst_cnt_ff <= 16'h0000;
            ctrl1_ff <= 8'h00;
            ctrl2_ff <= 8'h00;
            flag_ff <= 16'h0000;
            addr_hi_ff <= 8'h00;
            addr_ff <= 24'h000000;
            cnt_ff <= 16'h0000;
            upper_ff <= 16'h0000;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            rsv_warn_ff <= 1'b0;
            cmd_ff <= 1'b0;
            cmd_io_ff <= 1'b0;
            cmd_mem16_ff <= 1'b0;
            cmd_addr_ff <= 24'h000000;
            cmd_data_ff <= 24'h000000;
        end else begin
            cmd_ff <= 1'b0;
            if (start) begin
                // A new start aborts whatever ran and reboots the target
                state_ff <= S_RESET;
                rst_cnt_ff <= RST_CYC;
                done_ff <= 1'b0;
                err_ff <= 1'b0;
                rsv_warn_ff <= 1'b0;
            end else begin
                case (state_ff)
                    S_IDLE: begin
                        state_ff <= S_IDLE;
                    end
                    S_RESET: begin
                        if (rst_cnt_ff <= 16'h0001) begin
                            state_ff <= S_CTRL1;
                        end else begin
                            rst_cnt_ff <= rst_cnt_ff - 16'h0001;
                        end
                    end
                    S_CTRL1: begin
                        if (img_take) begin
                            ctrl1_ff <= word[7:0];
                            state_ff <= S_CTRL2;
                        end
                    end
                    S_CTRL2: begin
                        if (img_take) begin
                            ctrl2_ff <= word[7:0];
                            state_ff <= S_FLAG;
                        end
                    end
                    S_FLAG: begin
                        if (img_take) begin
                            flag_ff <= word;
                            state_ff <= S_AHI;
                        end
                    end
                    S_AHI: begin
                        if (img_take) begin
                            addr_hi_ff <= word[7:0];
                            if (word[15:8] != 8'h00) begin
                                err_ff <= 1'b1;
                                state_ff <= S_ERROR;
                            end else begin
                                state_ff <= S_ALO;
                            end
                        end
                    end
                    S_ALO: begin
                        if (img_take) begin
                            addr_ff <= {addr_hi_ff, word};
                            state_ff <= S_COUNT;
                        end
                    end
                    S_COUNT: begin
                        if (img_take) begin
                            cnt_ff <= word;
                            if (word == 16'h0000) begin
                                state_ff <= after_block;
                            end else if (is_zero) begin
                                state_ff <= S_ZERO;
                            end else begin
                                state_ff <= S_DHI;
                            end
                        end
                    end
                    S_DHI: begin
                        if (img_take) begin
                            if (is_mem16) begin
                                cmd_ff <= 1'b1;
                                cmd_data_ff <= {8'h00, word};
                                cmd_io_ff <= 1'b0;
                                cmd_mem16_ff <= 1'b1;
                                cmd_addr_ff <= addr_ff;
                                rsv_warn_ff <= rsv_warn_ff | in_rsv;
                                addr_ff <= addr_ff + 24'h000001;
                                cnt_ff <= cnt_dec;
                                ret_ff <= after_write;
                                state_ff <= S_WAIT;
                            end else begin
                                upper_ff <= word;
                                state_ff <= S_DLO;
                            end
                        end
                    end
                    S_DLO: begin
                        if (img_take) begin
                            cmd_ff <= 1'b1;
                            cmd_data_ff <= {upper_ff, word[15:8]};
                            cmd_io_ff <= 1'b0;
                            cmd_mem16_ff <= 1'b0;
                            cmd_addr_ff <= addr_ff;
                            addr_ff <= addr_ff + 24'h000001;
                            cnt_ff <= cnt_dec;
                            ret_ff <= after_write;
                            state_ff <= S_WAIT;
                        end
                    end
                    S_ZERO: begin
                        cmd_ff <= 1'b1;
                        cmd_data_ff <= 24'h000000;
                        cmd_io_ff <= 1'b0;
                        cmd_mem16_ff <= is_mem16;
                        cmd_addr_ff <= addr_ff;
                        rsv_warn_ff <= rsv_warn_ff | in_rsv;
                        addr_ff <= addr_ff + 24'h000001;
                        cnt_ff <= cnt_dec;
                        ret_ff <= after_write;
                        state_ff <= S_WAIT;
                    end
                    S_WAIT: begin
                        // Next header is only read once this write completed
                        if (eng_done) begin
                            state_ff <= ret_ff;
                        end
                    end
                    S_SYSCFG: begin
                        cmd_ff <= 1'b1;
                        cmd_io_ff <= 1'b1;
                        cmd_mem16_ff <= 1'b1;
                        cmd_addr_ff <= `HBL_SYSCFG_ADDR;
                        cmd_data_ff <= {23'h000000, ctrl1_ff[`HBL_C1_SPI_SEL]};
                        ret_ff <= S_SEMA;
                        state_ff <= S_WAIT;
                    end
                    S_SEMA: begin
                        // Reached only after the final block is fully written
                        cmd_ff <= 1'b1;
                        cmd_io_ff <= 1'b1;
                        cmd_mem16_ff <= 1'b1;
                        cmd_addr_ff <= `HBL_SEMA_ADDR;
                        cmd_data_ff <= `HBL_SEMA_GO;
                        ret_ff <= S_DONE;
                        state_ff <= S_WAIT;
                    end
                    S_DONE: begin
                        done_ff <= 1'b1;
                    end
                    S_ERROR: begin
                        state_ff <= S_ERROR;
                    end
                    default: begin
                        state_ff <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // External port settings
    // ****************************************************************
    // Only meaningful while an external block is being written
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_cfg_valid_o <= 1'b0;
            ext_wait_o <= 3'h0;
            ext_clk_div_o <= 3'h0;
            ext_bus16_o <= 1'b0;
        end else if (state_ff == S_FLAG) begin
            ext_cfg_valid_o <= 1'b0;
        end else if (state_ff == S_COUNT) begin
            ext_cfg_valid_o <= is_ext;
            if (is_ext) begin
                ext_wait_o <= ctrl1_ff[`HBL_C1_WAIT_MSB:`HBL_C1_WAIT_LSB];
                ext_clk_div_o <= ctrl1_ff[`HBL_C1_DIV_MSB:`HBL_C1_DIV_LSB];
                ext_bus16_o <= flag_ff[`HBL_FLAG_EXT16];
            end
        end else if (state_ff == S_SYSCFG) begin
            ext_cfg_valid_o <= 1'b0;
        end
    end

    // ****************************************************************
    // Target write engine
    // ****************************************************************
    hbl_tgt_port u_port (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .cmd_i(cmd_ff),
        .cmd_io_i(cmd_io_ff),
        .cmd_mem16_i(cmd_mem16_ff),
        .cmd_addr_i(cmd_addr_ff),
        .cmd_data_i(cmd_data_ff),
        .busy_o(),
        .done_o(eng_done),
        .tgt_req_o(tgt_req_o),
        .tgt_io_o(tgt_io_o),
        .tgt_mem16_o(tgt_mem16_o),
        .tgt_addr_o(tgt_addr_o),
        .tgt_data_o(tgt_data_o),
        .tgt_ack_i(tgt_ack_i)
    );

endmodule
`default_nettype wire

// File: hbl_loader_chk.sv
// Port checker for the host boot image loader
`include "hbl_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module hbl_loader_chk (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Bus and straps
    input wire logic wb_ack_o,
    input wire logic op_select_strap_o,
    input wire logic boot_strap_lo_o,
    input wire logic boot_strap_hi_o,
    // Target port
    input wire logic tgt_req_o,
    input wire logic tgt_io_o,
    input wire logic tgt_mem16_o,
    input wire logic [23:0] tgt_addr_o,
    input wire logic [23:0] tgt_data_o,
    input wire logic tgt_ack_i,
    input wire logic ext_cfg_valid_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    logic req_d_ff;
    logic [23:0] prev_ff;
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_d_ff <= 1'b0;
            prev_ff <= 24'h000000;
        end else begin
            req_d_ff <= tgt_req_o;
            if (tgt_req_o && !req_d_ff) prev_ff <= tgt_addr_o;
        end
    end
    sequence s_ack_seen;
        tgt_req_o && $rose(tgt_ack_i);
    endsequence
    sequence s_new_io;
        tgt_req_o && !req_d_ff && tgt_io_o;
    endsequence
    a_strap_boot: assert property (!op_select_strap_o && !boot_strap_lo_o && boot_strap_hi_o)
        else $error("strap level wrong");
    a_req_hold: assert property (tgt_req_o && req_d_ff |-> $stable(tgt_addr_o) && $stable(tgt_data_o))
        else $error("write moved");
    a_req_drop: assert property (s_ack_seen |-> ##[1:4] !tgt_req_o)
        else $error("req held");
    a_sema_go: assert property (s_new_io and tgt_addr_o == `HBL_SEMA_ADDR |-> tgt_data_o == `HBL_SEMA_GO)
        else $error("semaphore value");
    a_sema_last: assert property (s_new_io and tgt_addr_o == `HBL_SEMA_ADDR |-> prev_ff == `HBL_SYSCFG_ADDR)
        else $error("semaphore order");
    a_mem16_width: assert property (tgt_req_o && !tgt_io_o && tgt_mem16_o |-> tgt_data_o[23:16] == 8'h00)
        else $error("16-bit data wide");
    a_ext_addr: assert property (tgt_req_o && !tgt_io_o |-> ext_cfg_valid_o == (tgt_addr_o[23:16] != 8'h00))
        else $error("external flag");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
endmodule
bind hbl_loader hbl_loader_chk u_chk (.clk_sys_i, .arst_n_i, .wb_ack_o, .op_select_strap_o,
    .boot_strap_lo_o, .boot_strap_hi_o, .tgt_req_o, .tgt_io_o, .tgt_mem16_o, .tgt_addr_o,
    .tgt_data_o, .tgt_ack_i, .ext_cfg_valid_o);
`default_nettype wire

// File: hbl_tgt_model.sv
// Target model: straps, host-boot idle loop, four-phase write port
`include "hbl_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module hbl_tgt_model (
    // Clock, target reset and straps
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [2:0] strap_i,
    // Write port
    input wire logic req_i,
    input wire logic [49:0] wr_i,
    input wire logic [3:0] lag_i,
    output logic ack_o,
    output logic run_o
);
    logic boot_ff;
    logic [3:0] wait_ff;
    logic [49:0] wlog[$];
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_ff <= (strap_i === 3'b001);
            run_o <= 1'b0;
            ack_o <= 1'b0;
            wait_ff <= 4'h0;
        end else if (req_i && !ack_o) begin
            wait_ff <= wait_ff + 4'h1;
            if (wait_ff == lag_i) begin
                ack_o <= 1'b1;
                wait_ff <= 4'h0;
                wlog.push_back(wr_i);
                // Idle until a one hits semaphore A; run_o means fetching from 0x000000
                if (boot_ff && wr_i[49] && wr_i[47:0] == {`HBL_SEMA_ADDR, `HBL_SEMA_GO}) run_o <= 1'b1;
            end
        end else if (!req_i) begin
            ack_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: hbl_loader_tb.sv
// Testbench for the host boot image loader
`include "hbl_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module hbl_loader_tb;
    logic clk_sys_i, arst_n_i, wb_cyc_i, wb_we_i;
    logic [3:0] wb_adr_i, lag;
    logic [31:0] wb_dat_i, q;
    logic [6:0] ext_seen;
    wire [31:0] wb_dat_o;
    wire [23:0] tgt_addr_o, tgt_data_o;
    wire [2:0] ext_wait_o, ext_clk_div_o;
    wire wb_ack_o, tgt_rst_n_o, op_select_strap_o, boot_strap_lo_o, boot_strap_hi_o, tgt_req_o;
    wire tgt_io_o, tgt_mem16_o, tgt_ack_i, ext_cfg_valid_o, ext_bus16_o, run;
    int bad_count, check_count, cyc_n;
    hbl_loader #(.TGT_RST_CYC(4)) u_dut (.clk_sys_i, .arst_n_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i),
        .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .tgt_rst_n_o,
        .op_select_strap_o, .boot_strap_lo_o, .boot_strap_hi_o, .tgt_req_o, .tgt_io_o,
        .tgt_mem16_o, .tgt_addr_o, .tgt_data_o, .tgt_ack_i, .ext_cfg_valid_o, .ext_wait_o,
        .ext_clk_div_o, .ext_bus16_o);
    hbl_tgt_model u_tgt (.clk_sys_i, .rst_n_i(tgt_rst_n_o), .req_i(tgt_req_o),
        .strap_i({op_select_strap_o, boot_strap_lo_o, boot_strap_hi_o}), .lag_i(lag),
        .wr_i({tgt_io_o, tgt_mem16_o, tgt_addr_o, tgt_data_o}), .ack_o(tgt_ack_i), .run_o(run));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [49:0] e, input logic [49:0] s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
    endtask
    // Image words only go in once the parser asks, else the bus stalls
    task automatic img(input logic [15:0] w);
        q = 0;
        while (q[4] !== 1'b1) wb(0, `HBL_REG_STATUS, 0);
        wb(1, `HBL_REG_IMAGE, {16'h0000, w});
    endtask
    task automatic settle();
        q = 1;
        for (int i = 0; i < 400 && q[0] === 1'b1; i++) wb(0, `HBL_REG_STATUS, 0);
    endtask
    task automatic t_reset();
        chk("straps", 3'b001, {op_select_strap_o, boot_strap_lo_o, boot_strap_hi_o});
        wb(0, 4'h2, 0);
        chk("unmapped", 0, q);
        wb(0, `HBL_REG_STATUS, 0);
        chk("status", `HBL_RESET_VALUE_STATUS, q);
    endtask
    task automatic t_error();
        wb(1, `HBL_REG_CTRL, 1);
        img(16'h0047);
        img(16'h0003);
        img(16'h0000);
        img(16'h0100);
        settle();
        chk("error", 1, q[2]);
        chk("writes", 0, u_tgt.wlog.size());
    endtask
    // Mixed image: 24-bit payload, empty, zero-fill, external final block
    task automatic t_boot(input logic [3:0] l);
        logic [15:0] w[$];
        logic [49:0] e[$];
        logic [49:0] s;
        w = '{16'h0047, 16'h0003, 16'h0000, 16'h0000, 16'h0010, 16'h0002, 16'h1234, 16'h56FF,
            16'hABCD, 16'hEF00, 16'h0001, 16'h0000, 16'h0300, 16'h0000, 16'h0005, 16'h0000,
            16'hFEF0, 16'h0003, 16'h0013, 16'h0001, 16'h0020, 16'h0001, 16'hBEEF};
        e = '{{2'b00, 24'h000010, 24'h123456}, {2'b00, 24'h000011, 24'hABCDEF},
            {2'b01, 24'h00FEF0, 24'h0}, {2'b01, 24'h00FEF1, 24'h0}, {2'b01, 24'h00FEF2, 24'h0},
            {2'b01, 24'h010020, 24'h00BEEF}, {2'b10, `HBL_SYSCFG_ADDR, 24'h000001},
            {2'b10, `HBL_SEMA_ADDR, `HBL_SEMA_GO}};
        lag <= l;
        u_tgt.wlog.delete();
        wb(1, `HBL_REG_CTRL, 1);
        foreach (w[i]) img(w[i]);
        settle();
        chk("count", e.size(), u_tgt.wlog.size());
        foreach (e[i]) begin
            s = u_tgt.wlog[i];
            if (s[49]) s[48] = 1'b0;
            chk("write", e[i], s);
        end
        chk("run", 1, run);
        chk("ext", 7'h71, ext_seen);
        chk("status", 4'hA, q[3:0]);
        wb(0, `HBL_REG_ADDR, 0);
        chk("addr", 24'h010021, q);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc_n++;
        if (!tgt_rst_n_o) ext_seen <= 7'h00;
        else if (ext_cfg_valid_o) ext_seen <= {ext_wait_o, ext_clk_div_o, ext_bus16_o};
        if (cyc_n == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i, lag, arst_n_i} = 0;
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_error();
        t_boot(4'h0);
        t_boot(4'h5);
        end_of_test();
    end
endmodule
`default_nettype wire
